// File: inc/ddc_consts.svh
`ifndef DDC_CONSTS_SVH
`define DDC_CONSTS_SVH

// register indices; byte address is four times the index
`define DDC_CTRL_IDX 12'h0310
`define DDC_INSEL_IDX 12'h0311
`define DDC_NCO_IDX 12'h0314
`define DDC_STATUS_IDX 12'h0317

// reset values
`define DDC_CTRL_RST 8'h00
`define DDC_INSEL_RST 8'h00
`define DDC_NCO_RST 8'h00

// control register fields
`define DDC_CTRL_C2R_BIT 3
`define DDC_CTRL_DEC_MSB 2
`define DDC_CTRL_DEC_LSB 0

// input select register fields
`define DDC_INSEL_EXT_MSB 7
`define DDC_INSEL_EXT_LSB 4
`define DDC_INSEL_Q_BIT 2
`define DDC_INSEL_I_BIT 0
`define DDC_INSEL_WMASK 8'hF5

// oscillator control register fields
`define DDC_NCO_MODE_MSB 7
`define DDC_NCO_MODE_LSB 4
`define DDC_NCO_CHAN_MSB 3
`define DDC_NCO_CHAN_LSB 0

// primary decimation codes
`define DDC_DEC_HB12 3'h0
`define DDC_DEC_HB123 3'h1
`define DDC_DEC_HB1234 3'h2
`define DDC_DEC_HB1 3'h3
`define DDC_DEC_HB1_TB2 3'h4
`define DDC_DEC_HB12_TB2 3'h5
`define DDC_DEC_HB123_TB2 3'h6
`define DDC_DEC_EXT 3'h7

// extended decimation codes
`define DDC_EXT_ALL_TB2 4'h0
`define DDC_EXT_FB_HB1 4'h2
`define DDC_EXT_FB_HB12 4'h3
`define DDC_EXT_FB_HB123 4'h4
`define DDC_EXT_TB1 4'h7
`define DDC_EXT_FB_TB1 4'h8
`define DDC_EXT_HB2_FB_TB1 4'h9

// stage enable bit positions
`define DDC_STG_HB1 0
`define DDC_STG_HB2 1
`define DDC_STG_HB3 2
`define DDC_STG_HB4 3
`define DDC_STG_TB1 4
`define DDC_STG_TB2 5
`define DDC_STG_FB 6

// oscillator channel select modes
`define DDC_NCO_MODE_REG 4'h0
`define DDC_NCO_MODE_B0A0 4'h1
`define DDC_NCO_MODE_B1A1 4'h2
`define DDC_NCO_MODE_A1A0 4'h3
`define DDC_NCO_MODE_B1B0 4'h4
`define DDC_NCO_MODE_MIX 4'h5
`define DDC_NCO_MODE_PAIR 4'h6
`define DDC_NCO_MODE_EDGE_A0 4'h8
`define DDC_NCO_MODE_EDGE_B1 4'hB

`endif

// File: inc/ddc_pkg.sv
package ddc_pkg;

	// complete state of the down-converter control block
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] insel;
		logic [7:0] nco;
		logic [31:0] prdata;
		logic pslverr;
		logic [3:0] pin_prev;
		logic [3:0] edge_count;
		logic [3:0] nco_chan;
		logic [5:0] dcount;
		logic [1:0] mix_phase;
		logic [15:0] out_i;
		logic [15:0] out_q;
		logic out_valid;
		logic q_valid;
	} state_t;

endpackage : ddc_pkg

// File: logic/ddc_chain_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "ddc_consts.svh"

module ddc_chain_decode (
	input wire logic [2:0] primary_i,
	input wire logic [3:0] extended_i,
	input wire logic c2r_i,
	output logic [6:0] stage_en_o,
	output logic [5:0] ratio_o,
	output logic unsupported_o
);

	logic [5:0] cplx_ratio;
	logic no_half;

	// map the decimation codes onto a filter chain and its complex ratio
	always_comb begin
		stage_en_o = 7'h00;
		cplx_ratio = 6'd1;
		no_half = 1'b0;
		unsupported_o = 1'b0;
		case (primary_i)
			`DDC_DEC_HB12: begin
				stage_en_o = 7'h03;
				cplx_ratio = 6'd4;
			end
			`DDC_DEC_HB123: begin
				stage_en_o = 7'h07;
				cplx_ratio = 6'd8;
			end
			`DDC_DEC_HB1234: begin
				stage_en_o = 7'h0F;
				cplx_ratio = 6'd16;
			end
			`DDC_DEC_HB1: begin
				stage_en_o = 7'h01;
				cplx_ratio = 6'd2;
			end
			`DDC_DEC_HB1_TB2: begin
				stage_en_o = 7'h21;
				cplx_ratio = 6'd6;
			end
			`DDC_DEC_HB12_TB2: begin
				stage_en_o = 7'h23;
				cplx_ratio = 6'd12;
			end
			`DDC_DEC_HB123_TB2: begin
				stage_en_o = 7'h27;
				cplx_ratio = 6'd24;
			end
			default: begin
				// extended field only counts here
				case (extended_i)
					`DDC_EXT_ALL_TB2: begin
						stage_en_o = 7'h2F;
						cplx_ratio = 6'd48;
					end
					`DDC_EXT_FB_HB1: begin
						stage_en_o = 7'h41;
						cplx_ratio = 6'd10;
					end
					`DDC_EXT_FB_HB12: begin
						stage_en_o = 7'h43;
						cplx_ratio = 6'd20;
					end
					`DDC_EXT_FB_HB123: begin
						stage_en_o = 7'h47;
						cplx_ratio = 6'd40;
					end
					`DDC_EXT_TB1: begin
						stage_en_o = 7'h10;
						cplx_ratio = 6'd3;
						no_half = 1'b1;
					end
					`DDC_EXT_FB_TB1: begin
						stage_en_o = 7'h50;
						cplx_ratio = 6'd15;
						no_half = 1'b1;
					end
					`DDC_EXT_HB2_FB_TB1: begin
						stage_en_o = 7'h52;
						cplx_ratio = 6'd30;
						no_half = 1'b1;
					end
					default: begin
						unsupported_o = 1'b1; // reserved code: pass-through
					end
				endcase
			end
		endcase
		// real output halves the ratio where the chain allows it
		if (c2r_i && no_half) begin
			unsupported_o = 1'b1;
			ratio_o = cplx_ratio;
		end else if (c2r_i && !unsupported_o) begin
			// a reserved code keeps its pass-through ratio of one
			ratio_o = {1'b0, cplx_ratio[5:1]};
		end else begin
			ratio_o = cplx_ratio;
		end
	end

endmodule : ddc_chain_decode
`default_nettype wire

// File: logic/ddc_decimation_input_nco_select.sv
// Overview of operation
// - complex-to-real set: only real I stream, made by quarter-rate mixing
// - codes 000/001/010 cascade two, three, four half-band stages
// - code 011 uses first half-band stage only, ratio 2 or 1
// - codes 100/101/110 add second third-band after one to three half-bands
// - primary code 111 takes decimation from input select upper nibble
// - extended field ignored unless primary field is all ones
// - extended 0 chains four half-bands and second third-band, 48 or 24
// - extended 2/3/4 put fifth-band after one to three half-bands
// - extended 7/8/9 use first third-band; halved real rates unsupported
// - channel select mode picks register field or pin pairs
// - edge mode counter wraps to zero after reaching channel field
// - modes 8 to 11 count rising edges of A0, A1, B0, B1
// - complex-to-real clear: both I and Q outputs carry valid data
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "ddc_consts.svh"

module ddc_decimation_input_nco_select (
	input wire logic mclk_i,
	input wire logic nrst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [15:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// converter samples
	input wire logic sample_valid_i,
	input wire logic [15:0] chan_a_i,
	input wire logic [15:0] chan_b_i,
	// channel select pins
	input wire logic pin_a_zero_i,
	input wire logic pin_a_one_i,
	input wire logic pin_b_zero_i,
	input wire logic pin_b_one_i,
	// toward the output framer
	output logic [15:0] out_i_o,
	output logic [15:0] out_q_o,
	output logic out_valid_o,
	output logic out_q_valid_o,
	output logic [3:0] nco_channel_o,
	output logic [6:0] stage_enable_o,
	output logic [5:0] decim_ratio_o,
	output logic config_unsupported_o
);

	// ****************************************
	// helpers
	// ****************************************

	// byte address of a register index
	function automatic logic [15:0] reg_addr(input logic [11:0] idx);
		reg_addr = {2'b00, idx, 2'b00};
	endfunction : reg_addr

	// saturating negate keeps the most negative code in range
	function automatic logic [15:0] neg_sat(input logic [15:0] v);
		if (v == 16'h8000) begin
			neg_sat = 16'h7FFF;
		end else begin
			neg_sat = 16'h0000 - v;
		end
	endfunction : neg_sat

	// route one converter channel: clear picks A, set picks B
	function automatic logic [15:0] route(input logic sel, input logic [15:0] a,
		input logic [15:0] b);
		route = sel ? b : a;
	endfunction : route

	// true for the four edge-counting selection modes
	function automatic logic is_edge_mode(input logic [3:0] mode);
		is_edge_mode = (mode >= `DDC_NCO_MODE_EDGE_A0) && (mode <= `DDC_NCO_MODE_EDGE_B1);
	endfunction : is_edge_mode

	// one-hot register hit of a byte address: ctrl, insel, osc, status
	function automatic logic [3:0] reg_hit(input logic [15:0] a);
		reg_hit = 4'h0;
		if (a == reg_addr(`DDC_CTRL_IDX)) begin
			reg_hit = 4'h1;
		end
		if (a == reg_addr(`DDC_INSEL_IDX)) begin
			reg_hit = 4'h2;
		end
		if (a == reg_addr(`DDC_NCO_IDX)) begin
			reg_hit = 4'h4;
		end
		if (a == reg_addr(`DDC_STATUS_IDX)) begin
			reg_hit = 4'h8;
		end
	endfunction : reg_hit

	// channel number shown for each selection mode
	function automatic logic [3:0] pin_channel(input logic [3:0] mode, input logic [3:0] p,
		input logic [3:0] limit, input logic [3:0] count);
		case (mode)
			`DDC_NCO_MODE_REG: pin_channel = limit;
			`DDC_NCO_MODE_B0A0: pin_channel = {2'b00, p[2], p[0]};
			`DDC_NCO_MODE_B1A1: pin_channel = {2'b00, p[3], p[1]};
			`DDC_NCO_MODE_A1A0: pin_channel = {2'b00, p[1], p[0]};
			`DDC_NCO_MODE_B1B0: pin_channel = {2'b00, p[3], p[2]};
			`DDC_NCO_MODE_MIX: pin_channel = {p[3], p[1], p[2], p[0]};
			`DDC_NCO_MODE_PAIR: pin_channel = p;
			default: begin
				if (is_edge_mode(mode)) begin
					pin_channel = count;
				end else begin
					pin_channel = limit; // undefined modes fall back to the field
				end
			end
		endcase
	endfunction : pin_channel

	// ****************************************
	// state
	// ****************************************

	ddc_pkg::state_t st;
	ddc_pkg::state_t next_st;

	logic [6:0] stage_en;
	logic [5:0] ratio;
	logic unsupported;
	logic c2r;
	logic [3:0] pins;
	logic [3:0] pin_rise;
	logic [3:0] nco_mode;
	logic [3:0] nco_limit;
	logic [15:0] sel_i;
	logic [15:0] sel_q;
	logic [15:0] mixed;
	logic setup;
	logic access;
	logic mapped;
	logic [3:0] hit;
	logic last_sample;

	// ****************************************
	// decimation chain decode
	// ****************************************

	// the decoder sees both fields and ignores the extended one unless chosen
	// outputs follow the registers with no delay, so a rewrite of the
	// rate takes hold on the very next accepted sample
	ddc_chain_decode u_decode (
		.primary_i(st.ctrl[`DDC_CTRL_DEC_MSB:`DDC_CTRL_DEC_LSB]),
		.extended_i(st.insel[`DDC_INSEL_EXT_MSB:`DDC_INSEL_EXT_LSB]),
		.c2r_i(c2r),
		.stage_en_o(stage_en),
		.ratio_o(ratio),
		.unsupported_o(unsupported)
	);

	// ****************************************
	// combinational decode of controls
	// ****************************************

	// field views and bus phases
	assign c2r = st.ctrl[`DDC_CTRL_C2R_BIT];
	assign nco_mode = st.nco[`DDC_NCO_MODE_MSB:`DDC_NCO_MODE_LSB];
	assign nco_limit = st.nco[`DDC_NCO_CHAN_MSB:`DDC_NCO_CHAN_LSB];
	assign pins = {pin_b_one_i, pin_b_zero_i, pin_a_one_i, pin_a_zero_i};
	assign pin_rise = pins & ~st.pin_prev;
	assign setup = psel_i && !penable_i;
	assign access = psel_i && penable_i;

	// input routing: clear picks channel A, set picks channel B
	assign sel_i = route(st.insel[`DDC_INSEL_I_BIT], chan_a_i, chan_b_i);
	assign sel_q = route(st.insel[`DDC_INSEL_Q_BIT], chan_a_i, chan_b_i);

	// decimation counter reaches the end of a group
	// the compare is at-or-above so that lowering the ratio mid-group
	// closes the group at once instead of running the counter round
	// filtering itself is not modelled: one sample of each group is kept
	assign last_sample = ({2'b00, st.dcount} + 8'd1) >= {2'b00, ratio};

	// quarter-rate mix to real: I, Q, -I, -Q in turn
	// negation saturates: the most negative code has no positive twin
	// the phase runs on every accepted sample, kept or not
	always_comb begin
		case (st.mix_phase)
			2'd0: mixed = sel_i;
			2'd1: mixed = sel_q;
			2'd2: mixed = neg_sat(sel_i);
			2'd3: mixed = neg_sat(sel_q);
			default: mixed = sel_i;
		endcase
	end

	// address decode of the four registers
	// any address outside them answers with an error and reads zero
	assign hit = reg_hit(paddr_i);
	assign mapped = |hit;

	// ****************************************
	// next state
	// ****************************************

	always_comb begin
		next_st = st;

		// read data and error are captured in setup, shown in access
		// capturing early lets the answer stand for the whole access cycle
		// and keeps the slave free of wait states
		if (setup) begin
			next_st.pslverr = !mapped;
			next_st.prdata = 32'h0000_0000;
			if (!pwrite_i) begin
				case (hit)
					4'h1: next_st.prdata = {24'h00_0000, st.ctrl};
					4'h2: next_st.prdata = {24'h00_0000, st.insel};
					4'h4: next_st.prdata = {24'h00_0000, st.nco};
					4'h8: next_st.prdata = {8'h00, 1'b0, stage_en, 2'b00, ratio,
						3'b000, unsupported, st.nco_chan};
					default: next_st.prdata = 32'h0000_0000; // unmapped reads zero
				endcase
			end
		end

		// register writes take effect at the end of the access phase
		if (access && pwrite_i) begin
			case (hit)
				4'h1: next_st.ctrl = pwdata_i[7:0];
				4'h2: next_st.insel = pwdata_i[7:0] & `DDC_INSEL_WMASK; // reserved bits stay 0
				4'h4: begin
					next_st.nco = pwdata_i[7:0];
					next_st.edge_count = 4'h0; // restart counting on reprogram; a counted edge in the same cycle wins
				end
				default: begin
					// status is read-only and unmapped writes are dropped
				end
			endcase
		end

		// edge-controlled channel counter
		// the wrap test is at-or-above, so a limit lowered below the count
		// wraps on the next edge rather than after sixteen more
		next_st.pin_prev = pins;
		if (is_edge_mode(nco_mode)) begin
			if (pin_rise[nco_mode[1:0]]) begin
				if (st.edge_count >= nco_limit) begin
					next_st.edge_count = 4'h0;
				end else begin
					next_st.edge_count = st.edge_count + 4'h1;
				end
			end
		end

		// active oscillator channel, registered one cycle behind the pins, two behind in the edge modes
		// pins are taken as synchronous; no filtering of glitches is done
		next_st.nco_chan = pin_channel(nco_mode, pins, nco_limit, st.edge_count);

		// sample path: keep one sample of every group of ratio
		// valid flags are single-cycle pulses; data holds until the next
		// kept sample so the framer may take it late
		next_st.out_valid = 1'b0;
		next_st.q_valid = 1'b0;
		if (sample_valid_i) begin
			next_st.mix_phase = st.mix_phase + 2'd1;
			if (last_sample) begin
				next_st.dcount = 6'd0;
				next_st.out_valid = 1'b1;
				if (c2r) begin
					next_st.out_i = mixed;
					next_st.out_q = 16'h0000; // q carries nothing in real mode
				end else begin
					next_st.out_i = sel_i;
					next_st.out_q = sel_q;
					next_st.q_valid = 1'b1;
				end
			end else begin
				next_st.dcount = st.dcount + 6'd1;
			end
		end
	end

	// ****************************************
	// state register
	// ****************************************

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st.ctrl <= `DDC_CTRL_RST;
			st.insel <= `DDC_INSEL_RST;
			st.nco <= `DDC_NCO_RST;
			st.prdata <= 32'h0000_0000;
			st.pslverr <= 1'b0;
			st.pin_prev <= 4'h0;
			st.edge_count <= 4'h0;
			st.nco_chan <= 4'h0;
			st.dcount <= 6'd0;
			st.mix_phase <= 2'd0;
			st.out_i <= 16'h0000;
			st.out_q <= 16'h0000;
			st.out_valid <= 1'b0;
			st.q_valid <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// outputs
	// ****************************************

	// bus answer: zero wait states, data captured in the setup cycle
	// the error flag is gated by the access phase so that a stale flag
	// from an earlier transfer never shows outside an access
	assign pready_o = 1'b1;
	assign prdata_o = st.prdata;
	assign pslverr_o = st.pslverr && access;

	// stream and configuration outputs
	assign out_i_o = st.out_i;
	assign out_q_o = st.out_q;
	assign out_valid_o = st.out_valid;
	assign out_q_valid_o = st.q_valid;
	assign nco_channel_o = st.nco_chan;
	assign stage_enable_o = stage_en;
	assign decim_ratio_o = ratio;
	assign config_unsupported_o = unsupported;

endmodule : ddc_decimation_input_nco_select
`default_nettype wire

// File: sim/ddc_decimation_input_nco_select_props.sv
`timescale 1ns/10ps
`default_nettype none
module ddc_decimation_input_nco_select_props (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [15:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic sample_valid_i,
	input wire logic [15:0] chan_a_i,
	input wire logic [15:0] chan_b_i,
	input wire logic pin_a_zero_i,
	input wire logic pin_b_zero_i,
	input wire logic [15:0] out_i_o,
	input wire logic [15:0] out_q_o,
	input wire logic out_valid_o,
	input wire logic out_q_valid_o,
	input wire logic [3:0] nco_channel_o,
	input wire logic [6:0] stage_enable_o,
	input wire logic [5:0] decim_ratio_o
);
	logic [7:0] ctrl;
	logic [7:0] insel;
	logic [7:0] osc;
	logic [1:0] phase;
	// expected real sample for a mix phase: I, Q, -I, -Q with saturation
	function automatic logic [15:0] mix_ref(input logic [1:0] ph, input logic [15:0] i,
		input logic [15:0] q);
		logic [15:0] s;
		s = ph[0] ? q : i;
		if (ph[1] && s == 16'h8000) begin
			mix_ref = 16'h7FFF;
		end else if (ph[1]) begin
			mix_ref = 16'h0000 - s;
		end else begin
			mix_ref = s;
		end
	endfunction : mix_ref
	// mix phase advances on every accepted sample
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			phase <= 2'h0;
		end else if (sample_valid_i) begin
			phase <= phase + 2'h1;
		end
	end
	// ************************
	// shadow copies of settings
	// ************************
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl <= 8'h00;
			insel <= 8'h00;
			osc <= 8'h00;
		end else if (psel_i && penable_i && pwrite_i) begin
			if (paddr_i == 16'h0C40) ctrl <= pwdata_i[7:0];
			if (paddr_i == 16'h0C44) insel <= pwdata_i[7:0] & 8'hF5;
			if (paddr_i == 16'h0C50) osc <= pwdata_i[7:0];
		end
	end
	// ************************
	// checks
	// ************************
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!nrst_i);
	// filter chain and ratio follow the settings
	a_half_band_chain: assert property (ctrl[2:0] < 3'h3 |->
		stage_enable_o == (7'h0F >> (3'h2 - ctrl[2:0]))
		&& decim_ratio_o == ((ctrl[3] ? 6'h02 : 6'h04) << ctrl[2:0]))
		else $error("half-band chain wrong");
	a_first_only: assert property (ctrl[2:0] == 3'h3 |->
		stage_enable_o == 7'h01 && decim_ratio_o == (ctrl[3] ? 6'h01 : 6'h02))
		else $error("single stage wrong");
	a_third_band_chain: assert property (ctrl[2] && ctrl[1:0] != 2'h3 |->
		stage_enable_o == (7'h20 | (7'h07 >> (3'h6 - ctrl[2:0])))
		&& decim_ratio_o == ((ctrl[3] ? 6'h03 : 6'h06) << ctrl[1:0]))
		else $error("third-band chain wrong");
	a_ext_full: assert property (ctrl[2:0] == 3'h7 && insel[7:4] == 4'h0 |->
		stage_enable_o == 7'h2F && decim_ratio_o == (ctrl[3] ? 6'h18 : 6'h30))
		else $error("extended full chain wrong");
	a_ext_ignored: assert property (ctrl[2:0] != 3'h7 && $stable(ctrl) |->
		$stable(stage_enable_o) && $stable(decim_ratio_o))
		else $error("extended field not ignored");
	// stream outputs
	a_real_q_off: assert property (out_valid_o && ctrl[3] && $past(ctrl[3]) |->
		!out_q_valid_o && out_q_o == 16'h0000)
		else $error("q stream active in real mode");
	a_real_mix: assert property (out_valid_o && $past(ctrl[3]) |->
		out_i_o == mix_ref($past(phase), $past(insel[0] ? chan_b_i : chan_a_i),
		$past(insel[2] ? chan_b_i : chan_a_i)))
		else $error("real mix wrong");
	a_cplx_pair: assert property (out_valid_o && !ctrl[3] && !$past(ctrl[3]) |->
		out_q_valid_o)
		else $error("q stream missing in complex mode");
	a_input_route: assert property (out_valid_o && !$past(ctrl[3]) |->
		out_i_o == $past(insel[0] ? chan_b_i : chan_a_i)
		&& out_q_o == $past(insel[2] ? chan_b_i : chan_a_i))
		else $error("input routing wrong");
	// oscillator channel selection
	a_reg_channel: assert property (osc[7:4] == 4'h0 |=>
		nco_channel_o == $past(osc[3:0]))
		else $error("register channel wrong");
	a_pin_channel: assert property (osc[7:4] == 4'h1 |=>
		nco_channel_o == {2'b00, $past(pin_b_zero_i), $past(pin_a_zero_i)})
		else $error("pin channel wrong");
endmodule : ddc_decimation_input_nco_select_props
`default_nettype wire

// File: sim/ddc_sample_source.sv
`timescale 1ns/10ps
`default_nettype none
module ddc_sample_source (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic slow_i,
	output logic valid_o,
	output logic [15:0] a_o,
	output logic [15:0] b_o
);
	logic [15:0] cnt;
	// ramp on a, byte-swapped on b with its low byte inverted; one in four when slow
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt <= 16'h0000;
			valid_o <= 1'b0;
			a_o <= 16'h0000;
			b_o <= 16'h0000;
		end else begin
			cnt <= cnt + 16'h0001;
			valid_o <= !slow_i || cnt[1:0] == 2'h0;
			a_o <= cnt;
			b_o <= {cnt[7:0], ~cnt[15:8]};
		end
	end
endmodule : ddc_sample_source
`default_nettype wire

// File: sim/ddc_decimation_input_nco_select_bench.sv
`timescale 1ns/10ps
`default_nettype none
module ddc_decimation_input_nco_select_bench;
	logic mclk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, slow, rerr;
	logic sample_valid_i, out_valid_o, out_q_valid_o, config_unsupported_o;
	logic [15:0] paddr_i, chan_a_i, chan_b_i, out_i_o, out_q_o;
	logic [31:0] pwdata_i, prdata_o, rdata, v;
	logic [31:0] seed = 32'h6e6f_770e;
	logic [3:0] pins, nco_channel_o;
	logic [6:0] stage_enable_o;
	logic [5:0] decim_ratio_o;
	logic [13:0] ex;
	logic [15:0] addr_tab [3] = '{16'h0C40, 16'h0C44, 16'h0C50};
	logic [7:0] ctrl_tab [5] = '{8'h03, 8'h0B, 8'h0C, 8'h07, 8'h01};
	logic [3:0] ext_tab [8] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'h1};
	int num_errors = 0, compares = 0, acc = 0, group = 0, nout = 0;

	ddc_decimation_input_nco_select dut_u (
		.mclk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
		.pready_o, .pslverr_o, .sample_valid_i, .chan_a_i, .chan_b_i,
		.pin_a_zero_i(pins[0]), .pin_a_one_i(pins[1]), .pin_b_zero_i(pins[2]),
		.pin_b_one_i(pins[3]), .out_i_o, .out_q_o, .out_valid_o, .out_q_valid_o,
		.nco_channel_o, .stage_enable_o, .decim_ratio_o, .config_unsupported_o
	);
	ddc_sample_source src_u (
		.mclk_i, .nrst_i, .slow_i(slow), .valid_o(sample_valid_i), .a_o(chan_a_i),
		.b_o(chan_b_i)
	);

	// ************************
	// helpers
	// ************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// expected {unsupported, stages, ratio} for a setting
	function automatic logic [13:0] expect_cfg(input logic [2:0] p, input logic [3:0] x,
		input logic c);
		logic [6:0] s;
		logic [5:0] r;
		logic u;
		u = 1'b0;
		case (p)
			3'h0, 3'h1, 3'h2: {s, r} = {7'h0F >> (3'h2 - p), 6'h04 << p};
			3'h3: {s, r} = {7'h01, 6'h02};
			3'h7: case (x)
				4'h0: {s, r} = {7'h2F, 6'h30};
				4'h2: {s, r} = {7'h41, 6'h0A};
				4'h3: {s, r} = {7'h43, 6'h14};
				4'h4: {s, r} = {7'h47, 6'h28};
				4'h7: {s, r} = {7'h10, 6'h03};
				4'h8: {s, r} = {7'h50, 6'h0F};
				4'h9: {s, r} = {7'h52, 6'h1E};
				default: {u, s, r} = {1'b1, 7'h00, 6'h01};
			endcase
			default: {s, r} = {7'h20 | (7'h07 >> (3'h6 - p)), 6'h06 << p[1:0]};
		endcase
		if (c && s[4])
			u = 1'b1;
		else if (c && !u)
			r = r >> 1;
		return {u, s, r};
	endfunction : expect_cfg

	task automatic close_out();
		if (num_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	task automatic stall();
		num_errors++;
		$display("MISMATCH %0t wait ran out", $time);
		close_out();
	endtask : stall

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 16);
		if (pready_o !== 1'b1) stall();
		rdata = prdata_o;
		rerr = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	task automatic wait_out(input int k);
		int n0;
		int t;
		n0 = nout;
		t = 0;
		while (nout < n0 + k && t < 2000) begin
			@(posedge mclk_i);
			t++;
		end
		if (nout < n0 + k) stall();
	endtask : wait_out

	// accepted samples between output pulses
	always @(posedge mclk_i) begin
		if (out_valid_o === 1'b1) begin
			group <= acc;
			acc <= int'(sample_valid_i);
			nout <= nout + 1;
		end else begin
			acc <= acc + int'(sample_valid_i);
		end
	end

	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	// ************************
	// main sequence
	// ************************
	initial begin
		{nrst_i, psel_i, penable_i, pwrite_i, slow} = 5'h00;
		paddr_i = 16'h0000;
		pwdata_i = 32'h0;
		pins = 4'h0;
		repeat (5) @(posedge mclk_i);
		nrst_i <= 1'b1;
		for (int r = 0; r < 3; r++) begin
			apb(1'b0, addr_tab[r], 32'h0);
			chk(rdata, 32'h0);
		end
		// every primary code, each defined extended code and reserved 1, both output kinds
		for (int k = 0; k < 31; k++) begin
			v = rnd();
			if (k % 15 > 6) v[7:4] = ext_tab[k % 15 - 7];
			v[2:0] = k % 15 > 6 ? 3'h7 : 3'(k % 15);
			v[3] = k > 14;
			apb(1'b1, 16'h0C44, v);
			apb(1'b1, 16'h0C40, {28'h0, v[3:0]});
			ex = expect_cfg(v[2:0], v[7:4], v[3]);
			@(posedge mclk_i);
			chk({18'h0, config_unsupported_o, stage_enable_o, decim_ratio_o}, {18'h0, ex});
		end
		// stream ratios with random routing and pacing
		for (int s = 0; s < 5; s++) begin
			v = rnd();
			slow <= v[1];
			apb(1'b1, 16'h0C44, (v & 32'h0000_0005) | 32'h0000_0020);
			apb(1'b1, 16'h0C40, {24'h0, ctrl_tab[s]});
			wait_out(3);
			ex = expect_cfg(ctrl_tab[s][2:0], 4'h2, ctrl_tab[s][3]);
			chk(32'(group), {26'h0, ex[5:0]});
		end
		// channel from register or pin pairs
		for (int m = 0; m < 7; m++) begin
			v = rnd();
			pins <= v[7:4];
			apb(1'b1, 16'h0C50, {24'h0, 4'(m), v[3:0]});
			repeat (3) @(posedge mclk_i);
			case (m)
				0: ex[3:0] = v[3:0];
				1: ex[3:0] = {2'h0, v[6], v[4]};
				2: ex[3:0] = {2'h0, v[7], v[5]};
				3: ex[3:0] = {2'h0, v[5], v[4]};
				4: ex[3:0] = {2'h0, v[7], v[6]};
				5: ex[3:0] = {v[7], v[5], v[6], v[4]};
				default: ex[3:0] = v[7:4];
			endcase
			chk({28'h0, nco_channel_o}, {28'h0, ex[3:0]});
		end
		// edge counting on each pin, wrapping after two
		for (int j = 0; j < 4; j++) begin
			pins <= 4'h0;
			apb(1'b1, 16'h0C50, {24'h0, 4'(8 + j), 4'h2});
			for (int e = 1; e < 5; e++) begin
				pins <= 4'h1 << j;
				repeat (2) @(posedge mclk_i);
				pins <= 4'h0;
				repeat (3) @(posedge mclk_i);
				chk({28'h0, nco_channel_o}, 32'(e % 3));
			end
		end
		// unmapped address and reserved bits
		apb(1'b1, 16'h0C48, 32'h0000_00FF);
		chk({31'h0, rerr}, 32'h1);
		apb(1'b1, 16'h0C44, 32'h0000_00FF);
		apb(1'b0, 16'h0C44, 32'h0);
		chk(rdata, 32'h0000_00F5);
		// status word: chain, ratio and edge-counted channel 1
		apb(1'b0, 16'h0C5C, 32'h0);
		ex = expect_cfg(3'h1, 4'hF, 1'b0);
		chk(rdata, {8'h00, 1'b0, ex[12:6], 2'b00, ex[5:0], 3'b000, ex[13], 4'h1});
		close_out();
	end
endmodule : ddc_decimation_input_nco_select_bench

bind ddc_decimation_input_nco_select ddc_decimation_input_nco_select_props props_u (
	.mclk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .sample_valid_i,
	.chan_a_i,
	.chan_b_i, .pin_a_zero_i, .pin_b_zero_i, .out_i_o, .out_q_o, .out_valid_o,
	.out_q_valid_o, .nco_channel_o, .stage_enable_o, .decim_ratio_o
);
`default_nettype wire
